// >>> rtl/sps_top.sv
// Stepper phase sequencer: pin sync, phase state, drive outputs
`timescale 1ns/1ps
`default_nettype none
module sps_top
  import sps_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic NRST_I,
  input wire logic STEP_I,
  input wire logic DIR_I,
  input wire logic STEP_SIZE_SELECT_I,
  input wire logic OUTPUT_DISABLE_I,
  input wire logic BOOST_TIMING_PIN_I,
  output logic SINK_A_FIRST_O,
  output logic SINK_A_SECOND_O,
  output logic SINK_B_FIRST_O,
  output logic SINK_B_SECOND_O,
  output logic BOOST_SOURCE_A_O,
  output logic BOOST_SOURCE_B_O,
  output logic ZERO_A_O,
  output logic ZERO_B_O
);

  sps_ctrl_type ctrl;
  logic step_d_r;
  logic step_d_nxt;
  logic step_fall;
  logic [2:0] pos_r;
  logic [2:0] pos_nxt;
  logic boost_act;
  sps_phase_type phase;
  logic zero_a;
  logic zero_b;
  sps_phase_type sink_n_r;
  sps_phase_type sink_n_nxt;
  logic [1:0] src_r;
  logic [1:0] src_nxt;
  logic [1:0] zero_r;
  logic [1:0] zero_nxt;

  // Decode a half-step position into the winding pattern
  function automatic sps_phase_type pos_decode(input logic [2:0] p);
    sps_phase_type ph;
    ph = '0;
    unique case (p)
      3'h0: ph = '{a_first: 1'b1, a_second: 1'b0, b_first: 1'b1, b_second: 1'b0};
      3'h1: ph = '{a_first: 1'b0, a_second: 1'b0, b_first: 1'b1, b_second: 1'b0};
      3'h2: ph = '{a_first: 1'b0, a_second: 1'b1, b_first: 1'b1, b_second: 1'b0};
      3'h3: ph = '{a_first: 1'b0, a_second: 1'b1, b_first: 1'b0, b_second: 1'b0};
      3'h4: ph = '{a_first: 1'b0, a_second: 1'b1, b_first: 1'b0, b_second: 1'b1};
      3'h5: ph = '{a_first: 1'b0, a_second: 1'b0, b_first: 1'b0, b_second: 1'b1};
      3'h6: ph = '{a_first: 1'b1, a_second: 1'b0, b_first: 1'b0, b_second: 1'b1};
      3'h7: ph = '{a_first: 1'b1, a_second: 1'b0, b_first: 1'b0, b_second: 1'b0};
    endcase
    return ph;
  endfunction : pos_decode

  // Pins cross into the clock domain through two flops; they reset high
  sps_sync u_sync_step (.clk_i(CLK_SYS_I), .nrst_i(NRST_I), .d_i(STEP_I), .q_o(ctrl.step));
  sps_sync u_sync_dir (.clk_i(CLK_SYS_I), .nrst_i(NRST_I), .d_i(DIR_I), .q_o(ctrl.dir));
  sps_sync u_sync_size (.clk_i(CLK_SYS_I), .nrst_i(NRST_I), .d_i(STEP_SIZE_SELECT_I),
    .q_o(ctrl.step_size_select));
  sps_sync u_sync_dis (.clk_i(CLK_SYS_I), .nrst_i(NRST_I), .d_i(OUTPUT_DISABLE_I),
    .q_o(ctrl.output_disable));
  sps_sync u_sync_rc (.clk_i(CLK_SYS_I), .nrst_i(NRST_I), .d_i(BOOST_TIMING_PIN_I),
    .q_o(ctrl.boost_timing_pin));

  // Falling edge of the synchronised step; duty cycle is irrelevant
  assign step_fall = step_d_r & ~ctrl.step;

  // Position update: full-step jumps two places from the even code at or below the position and stays on even codes
  always_comb begin
    step_d_nxt = ctrl.step;
    pos_nxt = pos_r;
    if (step_fall) begin
      if (!ctrl.step_size_select) begin
        if (ctrl.dir) begin
          pos_nxt = pos_r + 3'h1;
        end else begin
          pos_nxt = pos_r - 3'h1;
        end
      end else begin
        // Snap odd position to even so full-step always drives two windings
        if (ctrl.dir) begin
          pos_nxt = {pos_r[2:1], 1'b0} + 3'h2;
        end else begin
          pos_nxt = {pos_r[2:1], 1'b0} - 3'h2;
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      step_d_r <= SPS_SYNC_RST;
      pos_r <= SPS_POS_RST;
    end else begin
      step_d_r <= step_d_nxt;
      pos_r <= pos_nxt;
    end
  end

  // Boost timer fires on every step; a low timing pin stretches it
  sps_boost u_boost (
    .clk_i(CLK_SYS_I),
    .nrst_i(NRST_I),
    .trig_i(step_fall),
    .hold_n_i(ctrl.boost_timing_pin),
    .active_o(boost_act)
  );

  // Winding pattern; odd positions leave one phase off
  assign phase = pos_decode(pos_r);
  assign zero_a = ~(phase.a_first | phase.a_second);
  assign zero_b = ~(phase.b_first | phase.b_second);

  // Output drive: sinks active low, sources active high, disable wins
  always_comb begin
    sink_n_nxt = ~phase;
    src_nxt[1] = boost_act & ~zero_a;
    src_nxt[0] = boost_act & ~zero_b;
    zero_nxt = {zero_a, zero_b};
    if (ctrl.output_disable) begin
      sink_n_nxt = '1;
      src_nxt = 2'h0;
    end
  end

  // All outputs registered; reset leaves windings off
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sink_n_r <= '1;
      src_r <= 2'h0;
      zero_r <= 2'h0;
    end else begin
      sink_n_r <= sink_n_nxt;
      src_r <= src_nxt;
      zero_r <= zero_nxt;
    end
  end

  assign SINK_A_FIRST_O = sink_n_r.a_first;
  assign SINK_A_SECOND_O = sink_n_r.a_second;
  assign SINK_B_FIRST_O = sink_n_r.b_first;
  assign SINK_B_SECOND_O = sink_n_r.b_second;
  assign BOOST_SOURCE_A_O = src_r[1];
  assign BOOST_SOURCE_B_O = src_r[0];
  assign ZERO_A_O = zero_r[1];
  assign ZERO_B_O = zero_r[0];

  // Checks beside the logic
  a_step_advance_one: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    (step_fall && !ctrl.step_size_select && ctrl.dir) |=> (pos_r == $past(pos_r) + 3'h1))
    else $error("half-step forward did not advance by one");
  a_no_step_hold: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    !step_fall |=> $stable(pos_r))
    else $error("position moved without a step edge");
  a_full_even_pos: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    (step_fall && ctrl.step_size_select) |=> (pos_r[0] == 1'b0))
    else $error("full-step left an odd position");
  a_full_rev_order: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    (step_fall && ctrl.step_size_select && !ctrl.dir && !pos_r[0]) |=> (pos_r == $past(pos_r) - 3'h2))
    else $error("full-step reverse order wrong");
  a_disable_all_off: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    ctrl.output_disable |=> (sink_n_r == '1) && (src_r == 2'h0))
    else $error("outputs on while disabled");
  a_zero_matches_sink: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    !$past(ctrl.output_disable) |-> (ZERO_A_O == (SINK_A_FIRST_O & SINK_A_SECOND_O)))
    else $error("zero A disagrees with phase A sinks");
  a_half_alternate: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    (step_fall && !ctrl.step_size_select) |=> ##1 ((zero_r != 2'h0) != (pos_r[0] == 1'b0)))
    else $error("half-step winding count did not alternate");
  a_boost_after_step: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    (step_fall && !ctrl.output_disable) ##1 !ctrl.output_disable |=> (BOOST_SOURCE_A_O | BOOST_SOURCE_B_O))
    else $error("no boost pulse after step");
  a_sink_active_low: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    !ctrl.output_disable |=> (sink_n_r == ~$past(phase)))
    else $error("sink polarity wrong");

endmodule : sps_top
`default_nettype wire

// >>> shared/sps_pkg.sv
// Shared constants and carrier types for the stepper phase sequencer
package sps_pkg;

  // Phase state width: eight half-step positions
  localparam int unsigned SPS_POS_W = 3;
  localparam logic [2:0] SPS_POS_RST = 3'h0;

  // Boost one-shot: time in ns, cycles derived at 25 MHz (longest time, rounded down)
  localparam int unsigned SPS_CLK_PERIOD_NS = 40;
  localparam int unsigned SPS_BOOST_TIME_NS = 20000;
  localparam int unsigned SPS_BOOST_CYC = SPS_BOOST_TIME_NS / SPS_CLK_PERIOD_NS;
  localparam int unsigned SPS_CNT_W = 10;
  localparam logic [9:0] SPS_CNT_RST = 10'h000;

  // Synchroniser reset level: unconnected inputs read high
  localparam logic SPS_SYNC_RST = 1'b1;

  // Phase drive pattern, one bit per winding end, 1 = energised
  typedef struct packed {
    logic a_first;
    logic a_second;
    logic b_first;
    logic b_second;
  } sps_phase_type;

  // Host control levels after synchronisation
  typedef struct packed {
    logic step;
    logic dir;
    logic step_size_select;
    logic output_disable;
    logic boost_timing_pin;
  } sps_ctrl_type;

endpackage : sps_pkg

// >>> rtl/sps_sync.sv
// Two-stage synchroniser for one asynchronous pin
`timescale 1ns/1ps
`default_nettype none
module sps_sync
  import sps_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic d_i,
  output logic q_o
);

  logic meta_r;
  logic meta_nxt;
  logic q_r;
  logic q_nxt;

  // Next values; first stage read only by the second
  always_comb begin
    meta_nxt = d_i;
    q_nxt = meta_r;
  end

  // Registers preset high, as an open input reads
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_r <= SPS_SYNC_RST;
      q_r <= SPS_SYNC_RST;
    end else begin
      meta_r <= meta_nxt;
      q_r <= q_nxt;
    end
  end

  assign q_o = q_r;

endmodule : sps_sync
`default_nettype wire

// >>> rtl/sps_boost.sv
// Retriggerable boost one-shot with external timing override
`timescale 1ns/1ps
`default_nettype none
module sps_boost
  import sps_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic trig_i,
  input wire logic hold_n_i,
  output logic active_o
);

  logic [9:0] cnt_r;
  logic [9:0] cnt_nxt;

  // Step loads the timer; a low timing pin keeps it loaded
  always_comb begin
    cnt_nxt = cnt_r;
    if (trig_i) begin
      cnt_nxt = SPS_BOOST_CYC[9:0];
    end else if (cnt_r != SPS_CNT_RST) begin
      if (!hold_n_i) begin
        cnt_nxt = cnt_r;
      end else begin
        cnt_nxt = cnt_r - 10'h001;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_r <= SPS_CNT_RST;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign active_o = (cnt_r != SPS_CNT_RST);

endmodule : sps_boost
`default_nettype wire

// >>> testbench/sps_host.sv
// Host step controller model that drives the step pin
`timescale 1ns/1ps
`default_nettype none
module sps_host (
  input wire logic clk_i,
  output logic step_o
);
  // Idle high, so reset release sees no falling edge
  initial step_o = 1'b1;
  // One step pulse: low then high for the counts given
  task automatic pulse(input int lo, input int hi);
    begin
      @(posedge clk_i);
      step_o <= 1'b0;
      repeat (lo) @(posedge clk_i);
      step_o <= 1'b1;
      repeat (hi) @(posedge clk_i);
    end
  endtask : pulse
endmodule : sps_host
`default_nettype wire

// >>> testbench/tb_stepper_phase_sequencer.sv
// Self-checking bench for the stepper phase sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_stepper_phase_sequencer;
  import sps_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, dir = 1'b1, size = 1'b1, dis = 1'b0, tim = 1'b1;
  logic s_a1, s_a2, s_b1, s_b2, l_a, l_b, z_a, z_b, d, f;
  wire logic step;
  logic [2:0] pos;
  int err_count = 0;
  int samples_checked = 0;
  int seed = 12;

  sps_host sps_host_inst (.clk_i(clk), .step_o(step));
  sps_top sps_top_inst (.CLK_SYS_I(clk), .NRST_I(nrst), .STEP_I(step), .DIR_I(dir),
    .STEP_SIZE_SELECT_I(size), .OUTPUT_DISABLE_I(dis), .BOOST_TIMING_PIN_I(tim),
    .SINK_A_FIRST_O(s_a1), .SINK_A_SECOND_O(s_a2), .SINK_B_FIRST_O(s_b1), .SINK_B_SECOND_O(s_b2),
    .BOOST_SOURCE_A_O(l_a), .BOOST_SOURCE_B_O(l_b), .ZERO_A_O(z_a), .ZERO_B_O(z_b));

  // Clock at 25 MHz
  initial begin
    forever #20 clk = ~clk;
  end

  // Expected pins from position; zero outputs ignore disable
  function automatic logic [7:0] exp_pins(input logic [2:0] p, input logic x, input logic bst);
    logic [3:0] e;
    case (p)
      3'h0: e = 4'ha;
      3'h1: e = 4'h2;
      3'h2: e = 4'h6;
      3'h3: e = 4'h4;
      3'h4: e = 4'h5;
      3'h5: e = 4'h1;
      3'h6: e = 4'h9;
      default: e = 4'h8;
    endcase
    return {x ? 4'hf : ~e, bst & ~x & |e[3:2], bst & ~x & |e[1:0], ~|e[3:2], ~|e[1:0]};
  endfunction : exp_pins

  // Compare at the falling edge, well clear of updates
  task automatic check(input logic [7:0] exp);
    begin
      @(negedge clk);
      samples_checked++;
      if ({s_a1, s_a2, s_b1, s_b2, l_a, l_b, z_a, z_b} !== exp) begin
        $display("ERROR t=%0t got=%h exp=%h", $time, {s_a1, s_a2, s_b1, s_b2, l_a, l_b, z_a, z_b}, exp);
        err_count++;
      end
    end
  endtask : check

  // One step with random duty; model advances its own position
  task automatic do_step(input logic dd, input logic ff, input logic xx, input logic tt);
    begin
      @(posedge clk);
      dir <= dd;
      size <= ff;
      dis <= xx;
      tim <= tt;
      sps_host_inst.pulse(3 + ($unsigned($random(seed)) % 4), 3 + ($unsigned($random(seed)) % 4));
      repeat (4) @(posedge clk);
      pos = pos + (ff ? (dd ? 3'h2 : 3'h6) : (dd ? 3'h1 : 3'h7));
    end
  endtask : do_step

  task automatic print_verdict;
    begin
      $display("checks=%0d mismatches=%0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask : print_verdict

  // Hang guard, far beyond the expected run
  initial begin
    #(40 * 8000);
    err_count++;
    print_verdict();
  end

  initial begin
    pos = 3'h0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    check(exp_pins(3'h0, 1'b0, 1'b0));
    $display("reset test done");
    // Directed: half wrap both ways, then full both ways
    for (int i = 0; i < 24; i++) begin
      do_step(i < 8 || (i >= 16 && i < 20), i >= 16, 1'b0, 1'b1);
      check(exp_pins(pos, 1'b0, 1'b1));
    end
    $display("directed sequence test done");
    // Random: full step only from an even position
    for (int i = 0; i < 48; i++) begin
      d = $random(seed);
      f = $random(seed);
      do_step(d, f & ~pos[0], ($unsigned($random(seed)) % 5) == 0, 1'b1);
      check(exp_pins(pos, dis, 1'b1));
    end
    $display("random step test done");
    // Boost expiry, then stretch by the timing pin
    do_step(1'b1, 1'b0, 1'b0, 1'b1);
    repeat (505) @(posedge clk);
    check(exp_pins(pos, 1'b0, 1'b0));
    do_step(1'b1, 1'b0, 1'b0, 1'b0);
    repeat (520) @(posedge clk);
    check(exp_pins(pos, 1'b0, 1'b1));
    @(posedge clk);
    tim <= 1'b1;
    repeat (520) @(posedge clk);
    check(exp_pins(pos, 1'b0, 1'b0));
    $display("boost test done");
    print_verdict();
  end
endmodule : tb_stepper_phase_sequencer
`default_nettype wire
